// ### tb/cfm_fab_model.sv
`timescale 1ns/100ps
module cfm_fab_model (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic slow_in,
   input wire logic i_rd_in,
   input wire logic d_rd_in,
   input wire logic d_wr_in,
   input wire logic [31:0] i_addr_in,
   input wire logic [31:0] d_addr_in,
   input wire logic [31:0] d_wdata_in,
   input wire logic [3:0] d_be_in,
   output logic i_wait_out,
   output logic i_rv_out,
   output logic d_wait_out,
   output logic [31:0] i_rdata_out,
   output logic [31:0] d_rdata_out
);
   logic [31:0] q[$];
   logic [31:0] m[16];
   logic [31:0] iq;
   logic [2:0] c;
   // slow: accept every other cycle, answer one in eight to fill the pipe
   assign i_wait_out = slow_in & c[0];
   assign d_wait_out = slow_in & c[0];
   // idle bus shows the inverse, never a stale word
   assign i_rdata_out = i_rv_out ? iq : ~iq;
   assign d_rdata_out = (d_rd_in && !d_wait_out) ? m[d_addr_in[5:2]] :
      ~m[d_addr_in[5:2]];
   always @(posedge sys_clk_in) begin
      c <= c + 3'h1;
      i_rv_out <= 1'b0;
      if (!rstn_in) begin
         q = {};
         c <= 3'h0;
         iq <= 32'h0;
      end else begin
         if (i_rd_in && !i_wait_out) q.push_back(i_addr_in);
         if (q.size() > 0 && (!slow_in || c == 3'h0)) begin
            i_rv_out <= 1'b1;
            iq <= {~q[0][15:0], q[0][15:0]};
            void'(q.pop_front());
         end
         if (d_wr_in && !d_wait_out)
            for (int b = 0; b < 4; b++)
               if (d_be_in[b])
                  m[d_addr_in[5:2]][8*b +: 8] <= d_wdata_in[8*b +: 8];
      end
   end
endmodule

// ### tb/cfm_ports_chk.sv
`timescale 1ns/100ps
module cfm_ports_chk import cfm_pkg::*; #(
   parameter int MAX_OUT = CFM_MAX_OUT
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic redirect_in,
   input wire logic pred_en_in,
   input wire logic [31:0] i_address_out,
   input wire logic [31:0] d_address_out,
   input wire logic i_read_out,
   input wire logic i_write_out,
   input wire logic i_waitrequest_in,
   input wire logic [3:0] i_byteenable_out,
   input wire logic i_readdatavalid_in,
   input wire logic instr_valid_out,
   input wire logic lsu_valid_in,
   input wire logic lsu_ready_out,
   input wire logic lsu_done_out,
   input wire logic d_read_out,
   input wire logic d_write_out,
   input wire logic d_waitrequest_in
);
   int cnt;
   logic acc;
   logic dbus;
   logic turned;
   assign acc = i_read_out && !i_waitrequest_in;
   assign dbus = d_read_out || d_write_out;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   // bus-level count: dropped words still hold a slot until they return
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) cnt <= 0;
      else cnt <= cnt + int'(acc) - int'(i_readdatavalid_in);
   end
   // a redirect during a stall moves the address only after that read
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) turned <= 1'b0;
      else if (redirect_in && i_read_out && i_waitrequest_in) turned <= 1'b1;
      else if (acc) turned <= 1'b0;
   end
   chk_no_iwrite: assert property (!i_write_out)
      else $error("instruction port wrote");
   chk_full_word: assert property (i_read_out |-> i_byteenable_out == 4'hf)
      else $error("narrow fetch");
   chk_ihold: assert property (i_read_out && i_waitrequest_in |=>
      i_read_out && $stable(i_address_out))
      else $error("fetch request dropped in wait");
   chk_seq_addr: assert property (acc && !redirect_in && !turned &&
      !pred_en_in |=> i_read_out |->
      i_address_out == $past(i_address_out) + 32'h4)
      else $error("fetch address not sequential");
   chk_max_out: assert property (cnt <= MAX_OUT)
      else $error("too many fetches outstanding");
   chk_valid_cause: assert property (instr_valid_out |-> $past(i_readdatavalid_in))
      else $error("instruction without bus data");
   chk_one_strobe: assert property (lsu_valid_in && lsu_ready_out |=> d_read_out ^ d_write_out)
      else $error("data access not started");
   chk_d_done: assert property (dbus && !d_waitrequest_in |=> lsu_done_out && !dbus)
      else $error("data access not completed");
   chk_d_hold: assert property (dbus && d_waitrequest_in |=> dbus && $stable(d_address_out))
      else $error("data access changed in wait");
   chk_busy_ready: assert property (dbus |-> !lsu_ready_out)
      else $error("ready while busy");
   cover property (acc ##1 acc);
   cover property (cnt == MAX_OUT);
   cover property (d_write_out && d_waitrequest_in);
   cover property (redirect_in && i_read_out && i_waitrequest_in);
endmodule
bind cfm_ports cfm_ports_chk #(.MAX_OUT(MAX_OUT)) i_cfm_ports_chk (.*);

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   import cfm_pkg::*;
   logic clk, rstn, redir, lvalid, slow, skip, ivld, ld, lrdy, ird, iwr, iwt;
   logic irv, drd, dwr, dwt;
   logic [31:0] raddr, iin, ipc, iad, dad, dwd, ird_d, drd_d, lrd, epc;
   logic [3:0] ibe, dbe;
   cfm_lsu_s lreq;
   int num_errors = 0;
   int cmp_count = 0;
   int nw = 0;
   cfm_ports i_cfm_ports (.sys_clk_in(clk), .rstn_in(rstn), .redirect_in(redir),
      .redirect_addr_in(raddr), .pred_en_in(1'b0), .instr_out(iin),
      .instr_pc_out(ipc), .instr_valid_out(ivld), .lsu_valid_in(lvalid),
      .lsu_req_in(lreq), .lsu_ready_out(lrdy), .lsu_rdata_out(lrd),
      .lsu_done_out(ld), .i_address_out(iad), .i_read_out(ird),
      .i_byteenable_out(ibe), .i_write_out(iwr), .i_waitrequest_in(iwt),
      .i_readdata_in(ird_d), .i_readdatavalid_in(irv), .d_address_out(dad),
      .d_read_out(drd), .d_write_out(dwr), .d_writedata_out(dwd),
      .d_byteenable_out(dbe), .d_waitrequest_in(dwt), .d_readdata_in(drd_d));
   cfm_fab_model i_cfm_fab_model (.sys_clk_in(clk), .rstn_in(rstn),
      .slow_in(slow), .i_rd_in(ird), .d_rd_in(drd), .d_wr_in(dwr),
      .i_addr_in(iad), .d_addr_in(dad), .d_wdata_in(dwd), .d_be_in(dbe),
      .i_wait_out(iwt), .i_rv_out(irv), .d_wait_out(dwt),
      .i_rdata_out(ird_d), .d_rdata_out(drd_d));
   task finish_test;
      if (num_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   always @(negedge clk) if (rstn && !skip && ivld === 1'b1) begin
      cmp(ipc, epc);
      cmp(iin, {~epc[15:0], epc[15:0]});
      epc += 32'h4;
      nw++;
   end
   task automatic t_fetch(input logic s, input logic [31:0] a);
      int n;
      slow = s;
      skip = 1;
      redir = 1;
      raddr = a;
      @(posedge clk);
      #1 redir = 0;
      epc = a;
      skip = 0;
      nw = 0;
      n = 0;
      while (nw < 12 && n < 300) begin @(posedge clk); #1 n++; end
      cmp(nw, 12);
   endtask
   task automatic lsu(input logic [31:0] a, w, input logic [1:0] sz,
      input logic wr, input logic [31:0] e);
      int n;
      lreq = '{a, w, sz, wr};
      lvalid = 1;
      n = 0;
      while (lrdy !== 1'b1 && n < 50) begin @(posedge clk); #1 n++; end
      @(posedge clk);
      #1 lvalid = 0;
      n = 0;
      while (ld !== 1'b1 && n < 50) begin @(posedge clk); #1 n++; end
      cmp({31'h0, ld}, 32'h1);
      if (!wr) cmp(lrd, e);
      @(posedge clk);
      #1;
   endtask
   task automatic t_mem(input logic s);
      slow = s;
      lsu(32'h40, 32'h11223344, CFM_SZ_WORD, 1'b1, 32'h0);
      lsu(32'h41, 32'hab, CFM_SZ_BYTE, 1'b1, 32'h0);
      lsu(32'h42, 32'hcdef, CFM_SZ_HALF, 1'b1, 32'h0);
      lsu(32'h40, 32'h0, CFM_SZ_WORD, 1'b0, 32'hcdefab44);
      lsu(32'h43, 32'h0, CFM_SZ_BYTE, 1'b0, 32'hcd);
      lsu(32'h40, 32'h0, CFM_SZ_HALF, 1'b0, 32'hab44);
      lsu(32'h80000044, 32'h5aa5, CFM_SZ_WORD, 1'b1, 32'h0);
      lsu(32'h80000044, 32'h0, CFM_SZ_WORD, 1'b0, 32'h5aa5);
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      num_errors++;
      finish_test;
   end
   initial begin
      {rstn, redir, lvalid, slow, skip} = 5'h0;
      {raddr, epc} = 64'h0;
      lreq = '0;
      repeat (3) @(posedge clk);
      #1 rstn = 1;
      repeat (20) @(posedge clk);
      #1;
      t_fetch(1'b1, 32'h200);
      t_fetch(1'b1, 32'h300);
      t_fetch(1'b0, 32'h1000);
      t_mem(1'b0);
      t_mem(1'b1);
      finish_test;
   end
endmodule

// ### verilog/cfm_fetch.sv
`timescale 1ns/100ps
module cfm_fetch import cfm_pkg::*; #(
   parameter int MAX_OUT = CFM_MAX_OUT
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic redirect_in,
   input wire logic [31:0] redirect_addr_in,
   input wire logic pred_en_in,
   output logic [31:0] i_address_out,
   output logic i_read_out,
   output logic [3:0] i_byteenable_out,
   output logic i_write_out,
   input wire logic i_waitrequest_in,
   input wire logic [31:0] i_readdata_in,
   input wire logic i_readdatavalid_in,
   output logic [31:0] instr_out,
   output logic [31:0] instr_pc_out,
   output logic instr_valid_out
);
   localparam int CW = $clog2(MAX_OUT + 1);
   localparam int QW = (MAX_OUT > 1) ? $clog2(MAX_OUT) : 1;
   logic [31:0] pc;
   logic [CW-1:0] outst;
   logic [CW-1:0] flush;
   logic [31:0] tagq [MAX_OUT];
   logic [QW-1:0] wp;
   logic [QW-1:0] rp;
   logic issue;
   logic take;
   logic [31:0] next_pc;
   logic stall;
   logic pend;
   logic jump;
   logic turn;
   logic [31:0] tgt;
   logic [31:0] dest;
   logic [31:0] guess;

   function automatic logic [QW-1:0] inc(input logic [QW-1:0] p);
      inc = (p == QW'(MAX_OUT - 1)) ? '0 : p + 1'b1;
   endfunction

   // static backward-taken guess on negative branch offsets
   function automatic logic [31:0] predict(input logic [31:0] a,
                                           input logic [31:0] w);
      logic [31:0] off;
      off = {{14{w[21]}}, w[21:6], 2'h0};
      if (w[5:0] == 6'h06 && w[CFM_PRED_BIT - 10])
         predict = a + off + CFM_WORD_STEP;
      else
         predict = a + CFM_WORD_STEP;
   endfunction

   assign issue = i_read_out && !i_waitrequest_in;
   assign take = i_readdatavalid_in;
   // a stalled read stays on the bus, even across a redirect
   assign i_read_out = stall ||
      ((outst < CW'(MAX_OUT)) && !redirect_in);
   assign i_address_out = pc;
   assign i_byteenable_out = CFM_BE_FULL;
   assign i_write_out = 1'b0;
   assign guess = predict(tagq[rp], i_readdata_in);
   assign jump = take && flush == '0 && pred_en_in && !redirect_in &&
                 guess != tagq[rp] + CFM_WORD_STEP;
   assign turn = redirect_in || jump;
   assign dest = redirect_in ? redirect_addr_in : guess;

   always_comb begin
      next_pc = pc;
      if (turn && !(i_read_out && i_waitrequest_in))
         next_pc = dest;
      else if (issue && pend)
         next_pc = tgt;
      else if (issue)
         next_pc = pc + CFM_WORD_STEP;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in)
         pc <= CFM_RESET_ADDR;
      else
         pc <= next_pc;
   end

   // a turn during a stall waits until the stalled read is taken
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         stall <= 1'b0;
         pend <= 1'b0;
         tgt <= CFM_RESET_ADDR;
      end else begin
         stall <= i_read_out && i_waitrequest_in;
         if (turn && i_read_out && i_waitrequest_in) begin
            pend <= 1'b1;
            tgt <= dest;
         end else if (issue || turn) begin
            pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         outst <= '0;
         wp <= '0;
         rp <= '0;
      end else begin
         outst <= outst + CW'(issue) - CW'(take);
         if (issue) begin
            tagq[wp] <= pc;
            wp <= inc(wp);
         end
         if (take)
            rp <= inc(rp);
      end
   end

   // stale words after a redirect are dropped, not cancelled on the bus
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in)
         flush <= '0;
      else if (turn)
         flush <= outst + CW'(i_read_out) - CW'(take);
      else if (take && flush != '0)
         flush <= flush - 1'b1;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         instr_out <= '0;
         instr_pc_out <= '0;
         instr_valid_out <= 1'b0;
      end else begin
         instr_valid_out <= take && flush == '0 && !redirect_in;
         if (take) begin
            instr_out <= i_readdata_in;
            instr_pc_out <= tagq[rp];
         end
      end
   end
endmodule

// ### verilog/cfm_pkg.sv
package cfm_pkg;
   localparam int CFM_AW = 32;
   localparam int CFM_DW = 32;
   localparam int CFM_BE_W = 4;
   localparam logic [3:0] CFM_BE_FULL = 4'hf;
   localparam logic [31:0] CFM_RESET_ADDR = 32'h00000000;
   localparam logic [31:0] CFM_WORD_STEP = 32'h00000004;
   localparam int CFM_MAX_OUT = 4;
   localparam int CFM_PRED_BIT = 31;

   // memory request toward the fabric
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic wr;
   } cfm_dreq_s;

   // load/store request from the core side
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] size;
      logic wr;
   } cfm_lsu_s;

   localparam logic [1:0] CFM_SZ_BYTE = 2'h0;
   localparam logic [1:0] CFM_SZ_HALF = 2'h1;
   localparam logic [1:0] CFM_SZ_WORD = 2'h2;
endpackage

// ### verilog/cfm_ports.sv
`timescale 1ns/100ps
// Operation
// - separate instruction and data bus masters
// - data reaches memory and peripherals; instruction memory
// - peripherals share data address space
// - little endian, high bytes at higher addresses
// - instruction port is 32-bit master
// - instruction port never writes
// - instruction reads may be pipelined
// - sequential prefetch and branch prediction
// - every fetch requests full 32 bits
// - access via instruction and data masters
// - data master not pipelined; latency as waits
// - store byte enables select written lanes
module cfm_ports import cfm_pkg::*; #(
   parameter int MAX_OUT = CFM_MAX_OUT
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic redirect_in,
   input wire logic [31:0] redirect_addr_in,
   input wire logic pred_en_in,
   output logic [31:0] instr_out,
   output logic [31:0] instr_pc_out,
   output logic instr_valid_out,
   input wire logic lsu_valid_in,
   input wire cfm_lsu_s lsu_req_in,
   output logic lsu_ready_out,
   output logic [31:0] lsu_rdata_out,
   output logic lsu_done_out,
   output logic [31:0] i_address_out,
   output logic i_read_out,
   output logic [3:0] i_byteenable_out,
   output logic i_write_out,
   input wire logic i_waitrequest_in,
   input wire logic [31:0] i_readdata_in,
   input wire logic i_readdatavalid_in,
   output logic [31:0] d_address_out,
   output logic d_read_out,
   output logic d_write_out,
   output logic [31:0] d_writedata_out,
   output logic [3:0] d_byteenable_out,
   input wire logic d_waitrequest_in,
   input wire logic [31:0] d_readdata_in
);
   typedef enum logic [1:0] {
      CFM_IDLE = 2'b01,
      CFM_BUSY = 2'b10
   } cfm_dstate_e;

   cfm_dstate_e state;
   cfm_dreq_s dreq;
   cfm_lsu_s held;

   // instruction master lives in its own module
   cfm_fetch #(.MAX_OUT(MAX_OUT)) u_fetch (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .redirect_in(redirect_in),
      .redirect_addr_in(redirect_addr_in),
      .pred_en_in(pred_en_in),
      .i_address_out(i_address_out),
      .i_read_out(i_read_out),
      .i_byteenable_out(i_byteenable_out),
      .i_write_out(i_write_out),
      .i_waitrequest_in(i_waitrequest_in),
      .i_readdata_in(i_readdata_in),
      .i_readdatavalid_in(i_readdatavalid_in),
      .instr_out(instr_out),
      .instr_pc_out(instr_pc_out),
      .instr_valid_out(instr_valid_out)
   );

   function automatic logic [3:0] lanes(input logic [1:0] sz,
                                        input logic [1:0] a);
      unique case (sz)
         CFM_SZ_BYTE: lanes = 4'h1 << a;
         CFM_SZ_HALF: lanes = a[1] ? 4'hc : 4'h3;
         default: lanes = CFM_BE_FULL;
      endcase
   endfunction

   // low byte or half of the value copied into every lane; byte enables pick the lane
   function automatic logic [31:0] place(input cfm_lsu_s r);
      unique case (r.size)
         CFM_SZ_BYTE: place = {4{r.wdata[7:0]}};
         CFM_SZ_HALF: place = {2{r.wdata[15:0]}};
         default: place = r.wdata;
      endcase
   endfunction

   function automatic logic [31:0] pick(input cfm_lsu_s r,
                                        input logic [31:0] d);
      logic [31:0] s;
      s = d >> {r.addr[1:0], 3'h0};
      unique case (r.size)
         CFM_SZ_BYTE: pick = {24'h0, s[7:0]};
         CFM_SZ_HALF: pick = {16'h0, s[15:0]};
         default: pick = d;
      endcase
   endfunction

   assign lsu_ready_out = (state == CFM_IDLE);
   // one access at a time; slave latency shows only as waitrequest
   assign d_address_out = dreq.addr;
   assign d_writedata_out = dreq.wdata;
   assign d_byteenable_out = dreq.be;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         state <= CFM_IDLE;
         dreq <= '0;
         held <= '0;
         d_read_out <= 1'b0;
         d_write_out <= 1'b0;
      end else begin
         unique case (state)
            CFM_IDLE: begin
               if (lsu_valid_in) begin
                  held <= lsu_req_in;
                  dreq.addr <= {lsu_req_in.addr[31:2], 2'h0};
                  dreq.wdata <= place(lsu_req_in);
                  dreq.be <= lanes(lsu_req_in.size,
                                   lsu_req_in.addr[1:0]);
                  dreq.wr <= lsu_req_in.wr;
                  d_read_out <= !lsu_req_in.wr;
                  d_write_out <= lsu_req_in.wr;
                  state <= CFM_BUSY;
               end
            end
            CFM_BUSY: begin
               if (!d_waitrequest_in) begin
                  d_read_out <= 1'b0;
                  d_write_out <= 1'b0;
                  state <= CFM_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         lsu_done_out <= 1'b0;
         lsu_rdata_out <= '0;
      end else begin
         lsu_done_out <= (state == CFM_BUSY) && !d_waitrequest_in;
         if (state == CFM_BUSY && !d_waitrequest_in && !dreq.wr)
            lsu_rdata_out <= pick(held, d_readdata_in);
      end
   end
endmodule
